// ===== src/led_stream_pkg.sv
package led_stream_pkg;

	// ----------------------------------------
	// clocking
	// ----------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MASTER_MHZ    = 48;
	localparam int LATCH_NS_DEF  = 50000;

	// ----------------------------------------
	// bus and register map
	// ----------------------------------------
	localparam int         ADDR_W      = 8;
	localparam int         DATA_W      = 32;
	localparam logic [7:0] OFF_CFG_LO  = 8'h00;
	localparam logic [7:0] OFF_CFG_HI  = 8'h04;
	localparam logic [7:0] OFF_BLOCK   = 8'h08;
	localparam logic [7:0] OFF_DATA    = 8'h0C;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	localparam logic [7:0] OFF_MODE_Q0 = 8'h14;
	localparam logic [7:0] OFF_MODE_Q1 = 8'h18;
	localparam logic [7:0] OFF_MODE_Q2 = 8'h1C;
	localparam logic [7:0] OFF_PIN_Q   = 8'h20;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// report fields
	// ----------------------------------------
	localparam logic [7:0] ENABLE_ON      = 8'h01;
	localparam logic [7:0] ENABLE_OFF     = 8'h00;
	localparam logic [7:0] REPORT_MODE_ID = 8'hFE;
	localparam logic [7:0] REPORT_PIN_ID  = 8'hFF;
	localparam int         SHIP_BIT       = 7;

	// ----------------------------------------
	// frame buffer geometry
	// ----------------------------------------
	localparam int          BLOCKS        = 25;
	localparam int          LEDS_PER_BLK  = 20;
	localparam int          BYTES_PER_LED = 3;
	localparam int          BLOCK_BYTES   = LEDS_PER_BLK * BYTES_PER_LED;
	localparam int          BUF_BYTES     = BLOCKS * BLOCK_BYTES;
	localparam int          BUF_AW        = 11;
	localparam logic [15:0] MAX_LEDS      = 16'h01F4;
	localparam logic [1:0]  LANE_LAST     = 2'h3;

	typedef enum logic [2:0] {SH_IDLE, SH_FETCH, SH_LOAD, SH_BIT, SH_LATCH} ship_state_t;

endpackage : led_stream_pkg

// ===== src/led_stream_store.sv
`timescale 1ns/10ps

// ----------------------------------------
// frame buffer, registered read data
// ----------------------------------------
module frame_memory #(
	parameter int AW    = 11,
	parameter int DEPTH = 1500
) (
	// clock
	input  wire logic          aclk,
	// write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// read side
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : frame_memory

// ----------------------------------------
// word fifo
// ----------------------------------------
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0]      cnt_r, cnt_nxt;
	logic             push, pop;

	assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wp_nxt  = push ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule : word_fifo

// ===== src/addressable_led_stream_driver.sv
`timescale 1ns/10ps

module addressable_led_stream_driver #(
	parameter int LATCH_NS   = led_stream_pkg::LATCH_NS_DEF,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	// axi4-lite write
	input  wire logic [led_stream_pkg::ADDR_W-1:0] awaddr,
	input  wire logic [2:0]                        awprot,
	input  wire logic                              awvalid,
	output logic                                   awready,
	input  wire logic [led_stream_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]                        wstrb,
	input  wire logic                              wvalid,
	output logic                                   wready,
	output logic      [1:0]                        bresp,
	output logic                                   bvalid,
	input  wire logic                              bready,
	// axi4-lite read
	input  wire logic [led_stream_pkg::ADDR_W-1:0] araddr,
	input  wire logic [2:0]                        arprot,
	input  wire logic                              arvalid,
	output logic                                   arready,
	output logic      [led_stream_pkg::DATA_W-1:0] rdata,
	output logic      [1:0]                        rresp,
	output logic                                   rvalid,
	input  wire logic                              rready,
	// other special functions
	input  wire logic                              i2c_active,
	input  wire logic                              lcd_active,
	input  wire logic                              led_matrix_active,
	input  wire logic [7:0]                        pin_group_a_state,
	input  wire logic [7:0]                        pin_group_b_state,
	// led chain and system
	output logic                                   led_data,
	output logic                                   led_matrix_hold,
	output logic                                   pin_change
);
	import led_stream_pkg::*;

	localparam int LATCH_CYC = (LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	function automatic logic writable(input logic [ADDR_W-1:0] a);
		return (a == OFF_CFG_LO) || (a == OFF_CFG_HI) || (a == OFF_BLOCK) || (a == OFF_DATA);
	endfunction : writable

	function automatic logic readable(input logic [ADDR_W-1:0] a);
		return writable(a) || (a == OFF_STATUS) || (a == OFF_MODE_Q0)
			|| (a == OFF_MODE_Q1) || (a == OFF_MODE_Q2) || (a == OFF_PIN_Q);
	endfunction : readable

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return m;
	endfunction : merge

	// ----------------------------------------
	// axi write channel
	// ----------------------------------------
	logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic              awready_r, awready_nxt, wready_r, wready_nxt;
	logic              bvalid_r, bvalid_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic [ADDR_W-1:0] waddr_r, waddr_nxt;
	logic [31:0]       wdata_r, wdata_nxt;
	logic [3:0]        wstrb_r, wstrb_nxt;
	logic              wr_ok, wr_go;
	logic              fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [31:0]       fifo_out_data;
	logic              armed_r;

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		waddr_nxt   = waddr_r;
		wdata_nxt   = wdata_r;
		wstrb_nxt   = wstrb_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		// a full fifo or a block still filling holds the write off
		unique case (waddr_r)
			OFF_DATA:  wr_ok = fifo_in_ready;
			OFF_BLOCK: wr_ok = !armed_r;
			default:   wr_ok = 1'b1;
		endcase
		wr_go = aw_hold_r && w_hold_r && !bvalid_r && wr_ok;
		if (awvalid && awready_r) begin
			aw_hold_nxt = 1'b1;
			waddr_nxt   = awaddr;
		end
		if (wvalid && wready_r) begin
			w_hold_nxt = 1'b1;
			wdata_nxt  = wdata;
			wstrb_nxt  = wstrb;
		end
		if (wr_go) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = writable(waddr_r) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_r && bready) begin
			bvalid_nxt = 1'b0;
		end
		awready_nxt = !aw_hold_nxt;
		wready_nxt  = !w_hold_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			waddr_r   <= '0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r  <= w_hold_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			waddr_r   <= waddr_nxt;
			wdata_r   <= wdata_nxt;
			wstrb_r   <= wstrb_nxt;
		end
	end

	// ----------------------------------------
	// configuration report
	// ----------------------------------------
	logic [31:0] cfg_lo_r, cfg_lo_nxt, cfg_hi_r, cfg_hi_nxt, cfg_new;
	logic        enabled_r, enabled_nxt;
	logic [7:0]  zero_cell_length_r, zero_cell_length_nxt, zero_high_length_r, zero_high_length_nxt;
	logic [7:0]  one_cell_length_r, one_cell_length_nxt, one_high_length_r, one_high_length_nxt;

	always_comb begin
		cfg_hi_nxt           = cfg_hi_r;
		enabled_nxt          = enabled_r;
		zero_cell_length_nxt = zero_cell_length_r;
		zero_high_length_nxt = zero_high_length_r;
		one_cell_length_nxt  = one_cell_length_r;
		one_high_length_nxt  = one_high_length_r;
		cfg_new              = merge(cfg_lo_r, wdata_r, wstrb_r);
		cfg_lo_nxt           = cfg_lo_r;
		if (wr_go && waddr_r == OFF_CFG_HI) begin
			cfg_hi_nxt = merge(cfg_hi_r, wdata_r, wstrb_r);
		end
		// the low word carries the enable byte, so writing it delivers the report
		if (wr_go && waddr_r == OFF_CFG_LO) begin
			cfg_lo_nxt = cfg_new;
			if (cfg_new[7:0] == ENABLE_ON) begin
				enabled_nxt          = 1'b1;
				zero_cell_length_nxt = cfg_new[15:8];
				zero_high_length_nxt = cfg_new[23:16];
				one_cell_length_nxt  = cfg_new[31:24];
				one_high_length_nxt  = cfg_hi_r[7:0];
			end else if (cfg_new[7:0] == ENABLE_OFF) begin
				enabled_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_lo_r           <= 32'h0000_0000;
			cfg_hi_r           <= 32'h0000_0000;
			enabled_r          <= 1'b0;
			zero_cell_length_r <= 8'h00;
			zero_high_length_r <= 8'h00;
			one_cell_length_r  <= 8'h00;
			one_high_length_r  <= 8'h00;
		end else begin
			cfg_lo_r           <= cfg_lo_nxt;
			cfg_hi_r           <= cfg_hi_nxt;
			enabled_r          <= enabled_nxt;
			zero_cell_length_r <= zero_cell_length_nxt;
			zero_high_length_r <= zero_high_length_nxt;
			one_cell_length_r  <= one_cell_length_nxt;
			one_high_length_r  <= one_high_length_nxt;
		end
	end

	// ----------------------------------------
	// block copy from fifo into frame buffer
	// ----------------------------------------
	logic [7:0]        blk_r, blk_nxt;
	logic [15:0]       cnt_r, cnt_nxt;
	logic [1:0]        lane_r, lane_nxt;
	logic [5:0]        byte_r, byte_nxt;
	logic              armed_nxt, start_r, start_nxt, drain, blk_ok, cnt_ok;
	logic [BUF_AW-1:0] mem_waddr, last_r, last_nxt;
	logic [7:0]        mem_wdata, mem_rdata;
	ship_state_t       ship_r, ship_nxt;

	always_comb begin
		armed_nxt = armed_r;
		blk_nxt   = blk_r;
		cnt_nxt   = cnt_r;
		lane_nxt  = lane_r;
		byte_nxt  = byte_r;
		last_nxt  = last_r;
		start_nxt = 1'b0;
		blk_ok    = blk_r[6:0] < 7'(BLOCKS);
		cnt_ok    = (cnt_r != 16'h0000) && (cnt_r <= MAX_LEDS);
		// the copy waits while a frame is out, so the frame never mixes old and new data
		drain          = armed_r && fifo_out_valid && (ship_r == SH_IDLE);
		fifo_out_ready = drain && (lane_r == LANE_LAST);
		mem_waddr      = BUF_AW'(int'(blk_r[6:0]) * BLOCK_BYTES) + BUF_AW'(byte_r);
		mem_wdata      = fifo_out_data[8*lane_r +: 8];
		if (wr_go && waddr_r == OFF_BLOCK) begin
			armed_nxt = 1'b1;
			blk_nxt   = wdata_r[7:0];
			cnt_nxt   = wdata_r[23:8];
			lane_nxt  = 2'h0;
			byte_nxt  = 6'h00;
		end
		if (drain) begin
			lane_nxt = lane_r + 2'h1;
			byte_nxt = byte_r + 6'h01;
			if (byte_r == 6'(BLOCK_BYTES - 1)) begin
				armed_nxt = 1'b0;
				byte_nxt  = 6'h00;
				// an out-of-range index is drained and dropped, and never shipped
				start_nxt = blk_r[SHIP_BIT] && blk_ok && cnt_ok && enabled_r;
				last_nxt  = BUF_AW'(int'(cnt_r) * BYTES_PER_LED - 1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_r <= 1'b0;
			blk_r   <= 8'h00;
			cnt_r   <= 16'h0000;
			lane_r  <= 2'h0;
			byte_r  <= 6'h00;
			last_r  <= '0;
			start_r <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
			blk_r   <= blk_nxt;
			cnt_r   <= cnt_nxt;
			lane_r  <= lane_nxt;
			byte_r  <= byte_nxt;
			last_r  <= last_nxt;
			start_r <= start_nxt;
		end
	end

	word_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) data_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (wr_go && waddr_r == OFF_DATA),
		.in_ready  (fifo_in_ready),
		.in_data   (wdata_r),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ----------------------------------------
	// serial shipper
	// ----------------------------------------
	logic [BUF_AW-1:0] ptr_r, ptr_nxt;
	logic [7:0]        shift_r, shift_nxt, cell_r, cell_nxt, acc_r, acc_nxt, acc_sum;
	logic [7:0]        cell_len, high_len;
	logic [2:0]        bit_r, bit_nxt;
	logic [15:0]       latch_r, latch_nxt;
	logic              tick, led_data_r, led_data_nxt, hold_r, hold_nxt;

	frame_memory #(
		.AW    (BUF_AW),
		.DEPTH (BUF_BYTES)
	) frame_buf (
		.aclk  (aclk),
		.we    (drain && blk_ok),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (ptr_r),
		.rdata (mem_rdata)
	);

	always_comb begin
		ship_nxt  = ship_r;
		ptr_nxt   = ptr_r;
		shift_nxt = shift_r;
		bit_nxt   = bit_r;
		cell_nxt  = cell_r;
		latch_nxt = latch_r;
		// fractional divider: 48 ticks in every 100 clocks
		acc_sum = acc_r + 8'(MASTER_MHZ);
		tick    = acc_sum >= 8'(CLK_MHZ);
		acc_nxt = tick ? acc_sum - 8'(CLK_MHZ) : acc_sum;
		cell_len = shift_r[7] ? one_cell_length_r : zero_cell_length_r;
		high_len = shift_r[7] ? one_high_length_r : zero_high_length_r;
		unique case (ship_r)
			SH_IDLE: begin
				if (start_r) begin
					ptr_nxt  = '0;
					ship_nxt = SH_FETCH;
				end
			end
			SH_FETCH: ship_nxt = SH_LOAD;
			SH_LOAD: begin
				shift_nxt = mem_rdata;
				bit_nxt   = 3'h7;
				cell_nxt  = 8'h00;
				ship_nxt  = SH_BIT;
			end
			SH_BIT: begin
				if (tick) begin
					cell_nxt = cell_r + 8'h01;
					if (cell_r == cell_len) begin
						cell_nxt  = 8'h00;
						bit_nxt   = bit_r - 3'h1;
						shift_nxt = {shift_r[6:0], 1'b0};
						if (bit_r == 3'h0) begin
							ptr_nxt  = ptr_r + 1'b1;
							ship_nxt = (ptr_r == last_r) ? SH_LATCH : SH_FETCH;
							latch_nxt = 16'h0000;
						end
					end
				end
			end
			SH_LATCH: begin
				latch_nxt = latch_r + 16'h0001;
				if (latch_r == 16'(LATCH_CYC - 1)) begin
					ship_nxt = SH_IDLE;
				end
			end
		endcase
		led_data_nxt = (ship_r == SH_BIT) && (cell_r <= high_len);
		hold_nxt     = (ship_nxt != SH_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ship_r     <= SH_IDLE;
			ptr_r      <= '0;
			shift_r    <= 8'h00;
			bit_r      <= 3'h0;
			cell_r     <= 8'h00;
			latch_r    <= 16'h0000;
			acc_r      <= 8'h00;
			led_data_r <= 1'b0;
			hold_r     <= 1'b0;
		end else begin
			ship_r     <= ship_nxt;
			ptr_r      <= ptr_nxt;
			shift_r    <= shift_nxt;
			bit_r      <= bit_nxt;
			cell_r     <= cell_nxt;
			latch_r    <= latch_nxt;
			acc_r      <= acc_nxt;
			led_data_r <= led_data_nxt;
			hold_r     <= hold_nxt;
		end
	end

	// ----------------------------------------
	// pin change detect and register reads
	// ----------------------------------------
	logic [15:0] pins_r, pins_nxt;
	logic        pin_change_r, pin_change_nxt;
	logic        arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt, rmux;
	logic [1:0]  rresp_r, rresp_nxt;

	always_comb begin
		pins_nxt       = {pin_group_b_state, pin_group_a_state};
		pin_change_nxt = (pins_nxt != pins_r);
		unique case (araddr)
			OFF_CFG_LO:  rmux = cfg_lo_r;
			OFF_CFG_HI:  rmux = cfg_hi_r;
			OFF_BLOCK:   rmux = {8'h00, cnt_r, blk_r};
			OFF_STATUS:  rmux = {29'h0000_0000, enabled_r, armed_r, ship_r != SH_IDLE};
			OFF_MODE_Q0: rmux = {8'h00, 7'h00, lcd_active, 7'h00, i2c_active,
				REPORT_MODE_ID};
			OFF_MODE_Q1: rmux = {24'h00_0000, 7'h00, led_matrix_active};
			OFF_MODE_Q2: rmux = {16'h0000, 7'h00, enabled_r, 8'h00};
			OFF_PIN_Q:   rmux = {8'h00, pin_group_b_state, pin_group_a_state,
				REPORT_PIN_ID};
			default:     rmux = 32'h0000_0000;
		endcase
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (arvalid && arready_r) begin
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b1;
			rdata_nxt   = rmux;
			rresp_nxt   = readable(araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_r && rready) begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins_r       <= 16'h0000;
			pin_change_r <= 1'b0;
			arready_r    <= 1'b1;
			rvalid_r     <= 1'b0;
			rdata_r      <= 32'h0000_0000;
			rresp_r      <= RESP_OKAY;
		end else begin
			pins_r       <= pins_nxt;
			pin_change_r <= pin_change_nxt;
			arready_r    <= arready_nxt;
			rvalid_r     <= rvalid_nxt;
			rdata_r      <= rdata_nxt;
			rresp_r      <= rresp_nxt;
		end
	end

	assign awready         = awready_r;
	assign wready          = wready_r;
	assign bvalid          = bvalid_r;
	assign bresp           = bresp_r;
	assign arready         = arready_r;
	assign rvalid          = rvalid_r;
	assign rdata           = rdata_r;
	assign rresp           = rresp_r;
	assign led_data        = led_data_r;
	assign led_matrix_hold = hold_r;
	assign pin_change      = pin_change_r;

endmodule : addressable_led_stream_driver

// ===== tb/led_chain_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// led chain: decodes each bit from its high width
// ----------------------------------------
module led_chain_model #(
	parameter int THR = 16
) (
	// clock and line
	input wire logic aclk,
	input wire logic led_data
);
	int         hc = 0;
	int         nb = 0;
	logic [7:0] sh;
	logic [7:0] q[$];

	// a wide pulse is a one, a narrow one a zero; msb arrives first
	always @(posedge aclk) begin
		if (led_data) begin
			hc <= hc + 1;
		end else if (hc > 0) begin
			sh = {sh[6:0], hc > THR};
			nb = nb + 1;
			hc <= 0;
			if (nb == 8) begin
				q.push_back(sh);
				nb = 0;
			end
		end
	end
endmodule : led_chain_model

// ===== tb/led_stream_asserts.sv
`timescale 1ns/10ps

module led_stream_asserts
	import led_stream_pkg::*;
(
	// clock and reset
	input wire logic                              aclk,
	input wire logic                              aresetn,
	// bus
	input wire logic [led_stream_pkg::ADDR_W-1:0] araddr,
	input wire logic                              arvalid,
	input wire logic                              arready,
	input wire logic [led_stream_pkg::DATA_W-1:0] rdata,
	input wire logic [1:0]                        rresp,
	input wire logic                              rvalid,
	input wire logic                              rready,
	input wire logic [1:0]                        bresp,
	input wire logic                              bvalid,
	input wire logic                              bready,
	// status inputs
	input wire logic                              i2c_active,
	input wire logic [7:0]                        pin_group_a_state,
	input wire logic [7:0]                        pin_group_b_state,
	// outputs
	input wire logic                              led_data,
	input wire logic                              led_matrix_hold,
	input wire logic                              pin_change
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_R_ONE: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	AST_AR_BUSY: assert property (rvalid |-> !arready)
		else $error("second read taken");
	AST_IDLE_LOW: assert property (!led_matrix_hold |-> !led_data)
		else $error("line high outside frame");
	AST_PIN_EVT: assert property ($past(aresetn) &&
		{pin_group_b_state, pin_group_a_state} != $past({pin_group_b_state,
		pin_group_a_state}) |=> pin_change)
		else $error("pin change missed");
	AST_PIN_RD: assert property (arvalid && arready && araddr == OFF_PIN_Q |=>
		rdata == {8'h00, $past(pin_group_b_state), $past(pin_group_a_state), 8'hFF})
		else $error("pin query wrong");
	AST_MODE_RD: assert property (arvalid && arready && araddr == OFF_MODE_Q0 |=>
		rdata[7:0] == REPORT_MODE_ID && (rdata[15:8] != 8'h00) == $past(i2c_active))
		else $error("mode query wrong");
	AST_BAD_RD: assert property (arvalid && arready && araddr == 8'h40 |=>
		rresp == RESP_SLVERR && rdata == 32'h0000_0000)
		else $error("unmapped read answered");
endmodule : led_stream_asserts

bind addressable_led_stream_driver led_stream_asserts chk_i (
	.aclk(aclk), .aresetn(aresetn), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.i2c_active(i2c_active), .pin_group_a_state(pin_group_a_state),
	.pin_group_b_state(pin_group_b_state), .led_data(led_data),
	.led_matrix_hold(led_matrix_hold), .pin_change(pin_change)
);

// ===== tb/testbench.sv
`timescale 1ns/10ps

module testbench;
	import led_stream_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        i2c_active, lcd_active, led_matrix_active;
	logic [7:0]  awaddr, araddr, pin_group_a_state, pin_group_b_state;
	logic [31:0] wdata, d;
	logic [1:0]  r;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic   led_data, led_matrix_hold, pin_change;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	logic [7:0]  mem [120];
	int          errors, num_checks, cyc;

	addressable_led_stream_driver #(.LATCH_NS(200), .FIFO_DEPTH(16)) uut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .i2c_active(i2c_active), .lcd_active(lcd_active),
		.led_matrix_active(led_matrix_active), .pin_group_a_state(pin_group_a_state),
		.pin_group_b_state(pin_group_b_state), .led_data(led_data),
		.led_matrix_hold(led_matrix_hold), .pin_change(pin_change));
	led_chain_model chain (.aclk(aclk), .led_data(led_data));

	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end

	task test_done;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : test_done

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			test_done();
		end
	end

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		// a late bready keeps the response standing for a cycle
		bready <= 1'($urandom);
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid && !bready) bready <= 1;
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1'($urandom);
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid && !rready) rready <= 1;
		end while (!(rvalid && rready));
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask : rd

	// block header then 15 words, lane 0 first
	task blk(input logic [7:0] b, input logic [15:0] n, input int base);
		chain.q.delete();
		wr(OFF_BLOCK, {8'h00, n, b});
		for (int k = 0; k < 60; k += 4)
			wr(OFF_DATA, {mem[base+k+3], mem[base+k+2], mem[base+k+1], mem[base+k]});
	endtask : blk

	task frame_chk(input int n);
		repeat (300) @(posedge aclk);
		while (led_matrix_hold) @(posedge aclk);
		chk("bytes", chain.q.size(), n);
		for (int i = 0; i < n; i++) chk("led byte", chain.q[i], mem[i]);
	endtask : frame_chk

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
		{wdata, i2c_active, lcd_active, led_matrix_active} = '0;
		{pin_group_a_state, pin_group_b_state} = '0;
		void'($urandom(32'h0000_b407));
		foreach (mem[i]) mem[i] = 8'($urandom);
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		// ----------------------------------------
		// queries with random pins and flags
		// ----------------------------------------
		for (int i = 0; i < 6; i++) begin
			{pin_group_a_state, pin_group_b_state, i2c_active, lcd_active} <= 18'($urandom);
			led_matrix_active <= 1'($urandom);
			@(posedge aclk);
			rd(OFF_PIN_Q);
			chk("pins", d, {8'h00, pin_group_b_state, pin_group_a_state, 8'hFF});
			rd(OFF_MODE_Q0);
			chk("mode0", {d[31:24], d[7:0], 6'h00, |d[23:16], |d[15:8]},
				{16'h00FE, 6'h00, lcd_active, i2c_active});
			rd(OFF_MODE_Q1);
			chk("matrix", |d[7:0], led_matrix_active);
		end
		rd(8'h40);
		chk("bad rd", {r, d[29:0]}, {RESP_SLVERR, 30'h0});
		wr(OFF_STATUS, 32'h0000_0004);
		chk("ro wr", r, RESP_SLVERR);
		// ----------------------------------------
		// enable, fill two blocks, ship 21 leds
		// ----------------------------------------
		wr(OFF_CFG_HI, 32'h0000_000B);
		wr(OFF_CFG_LO, 32'h0F03_0F01);
		rd(OFF_MODE_Q2);
		chk("single_wire_led_active", |d[15:8], 1'b1);
		blk(8'h00, 16'h0007, 0);
		frame_chk(0);
		blk(8'h81, 16'h0015, 60);
		frame_chk(63);
		// bad index, zero count, count above the maximum
		blk(8'h99, 16'h0001, 0);
		frame_chk(0);
		blk(8'h80, 16'h0000, 0);
		frame_chk(0);
		blk(8'h80, 16'h01F5, 0);
		frame_chk(0);
		// non-enabling config must not change the live timings
		wr(OFF_CFG_HI, 32'h0000_0001);
		wr(OFF_CFG_LO, 32'h0F0B_0F02);
		blk(8'h80, 16'h0001, 0);
		frame_chk(3);
		wr(OFF_CFG_LO, 32'h0000_0000);
		rd(OFF_STATUS);
		chk("enabled", d[2], 1'b0);
		test_done();
	end
endmodule : testbench
